// file: src/pcmc_map.svh
// Register offsets, field positions and reset values of the pace and common-mode config block.
`ifndef PCMC_MAP_SVH
`define PCMC_MAP_SVH

`define PCMC_ADDR_W 8
`define PCMC_DATA_W 24
`define PCMC_OFS_PACE 8'h04
`define PCMC_OFS_CMREF 8'h0C
`define PCMC_RST_PACE 24'h000F88
`define PCMC_RST_CMREF 24'hE00000
`define PCMC_MASK_PACE 24'h000FFF
`define PCMC_MASK_CMREF 24'hE073FF

`define PCMC_PACE_PWF 11
`define PCMC_PACE_VF2 10
`define PCMC_PACE_VF1 9
`define PCMC_PACE_CH3_SEL 7
`define PCMC_PACE_CH2_SEL 5
`define PCMC_PACE_CH1_SEL 3
`define PCMC_PACE_CH3_EN 2
`define PCMC_PACE_CH2_EN 1
`define PCMC_PACE_CH1_EN 0

`define PCMC_CM_LA 23
`define PCMC_CM_LL 22
`define PCMC_CM_RA 21
`define PCMC_DRV_LA 14
`define PCMC_DRV_LL 13
`define PCMC_DRV_RA 12
`define PCMC_DRV_CE 9
`define PCMC_CE_REF 8
`define PCMC_REFSEL_LSB 4
`define PCMC_CM_PIN 3
`define PCMC_EXT_CM 2
`define PCMC_DRV_REF 1
`define PCMC_SHIELD 0

`endif

// file: src/pcmc_pkg.sv
// Types shared by the pace and common-mode config block.
package pcmc_pkg;
   typedef enum logic [1:0] {
      PCMC_LEAD_I = 2'h0,
      PCMC_LEAD_II = 2'h1,
      PCMC_LEAD_III = 2'h2,
      PCMC_LEAD_AVF = 2'h3
   } pcmc_lead_t;

   typedef enum logic [3:0] {
      PCMC_DRV_PIN = 4'h0,
      PCMC_DRV_LA = 4'h1,
      PCMC_DRV_LL = 4'h2,
      PCMC_DRV_RA = 4'h3
   } pcmc_drvsel_t;

   // Source of the common-mode level, one-hot.
   typedef enum logic [3:0] {
      PCMC_CMS_AVG = 4'h1,
      PCMC_CMS_SINGLE = 4'h2,
      PCMC_CMS_INTREF = 4'h4,
      PCMC_CMS_EXT = 4'h8
   } pcmc_cm_src_t;
endpackage

// file: src/pcmc_cfg_reg.sv
// One 24-bit configuration register with reset value and writable mask.
`timescale 1ns/1ps
`default_nettype none
module pcmc_cfg_reg #(
   parameter logic [23:0] RST = 24'h000000,
   parameter logic [23:0] MASK = 24'hFFFFFF
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wr_en,
   input wire logic [23:0] wr_data,
   output logic [23:0] value_q
);
   // Reserved bits are never stored, so they always read as zero.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         value_q <= RST;
      end else if (wr_en) begin
         value_q <= wr_data & MASK;
      end
   end
endmodule // pcmc_cfg_reg
`default_nettype wire

// file: src/pcmc_cm_route.sv
// Common-mode source and switch decode from the electrode select and mode bits.
`timescale 1ns/1ps
`default_nettype none
module pcmc_cm_route
   import pcmc_pkg::*;
(
   input wire logic [2:0] cm_sel,
   input wire logic external_cm_choice,
   input wire logic cm_pin_output_on,
   output logic [2:0] cm_switch,
   output pcmc_cm_src_t cm_src,
   output logic cm_pin_drive
);
   always_comb begin
      if (external_cm_choice) begin
         cm_switch = 3'h0;
         cm_src = PCMC_CMS_EXT;
      end else begin
         cm_switch = cm_sel;
         case (cm_sel)
            3'h0: cm_src = PCMC_CMS_INTREF;
            3'h1, 3'h2, 3'h4: cm_src = PCMC_CMS_SINGLE;
            default: cm_src = PCMC_CMS_AVG;
         endcase
      end
      cm_pin_drive = cm_pin_output_on & ~external_cm_choice;
   end
endmodule // pcmc_cm_route
`default_nettype wire

// file: src/pcmc_top.sv
// Pace detection and common-mode reference configuration registers.
// ==========================================================
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "pcmc_map.svh"
module pcmc_top
   import pcmc_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] addr,
   input wire logic [23:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [23:0] rd_data_q,
   output logic pulse_width_filter_on_q,
   output logic validation_filter_two_on_q,
   output logic validation_filter_one_on_q,
   output pcmc_lead_t pulse_ch3_lead_choice_q,
   output pcmc_lead_t pulse_ch2_lead_choice_q,
   output pcmc_lead_t pulse_ch1_lead_choice_q,
   output logic [2:0] pulse_detect_on_q,
   output logic [2:0] cm_switch_q,
   output pcmc_cm_src_t cm_src_q,
   output logic cm_pin_drive_q,
   output logic [3:0] drive_sum_q,
   output logic shared_electrode_ref_on_q,
   output logic [3:0] drive_route_q,
   output logic drive_ref_on_q,
   output logic shield_drive_on_q
);
   // ==========================================================
   // Register file
   logic [23:0] pace_q;
   logic [23:0] cmref_q;
   logic pace_wr;
   logic cmref_wr;

   assign pace_wr = wr_en && (addr == `PCMC_OFS_PACE);
   assign cmref_wr = wr_en && (addr == `PCMC_OFS_CMREF);

   pcmc_cfg_reg #(
      .RST(`PCMC_RST_PACE),
      .MASK(`PCMC_MASK_PACE)
   ) u_pace (
      .clk(clk),
      .arst_n(arst_n),
      .wr_en(pace_wr),
      .wr_data(wr_data),
      .value_q(pace_q)
   );

   pcmc_cfg_reg #(
      .RST(`PCMC_RST_CMREF),
      .MASK(`PCMC_MASK_CMREF)
   ) u_cmref (
      .clk(clk),
      .arst_n(arst_n),
      .wr_en(cmref_wr),
      .wr_data(wr_data),
      .value_q(cmref_q)
   );

   // Unmapped addresses read as zero so software can probe safely.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data_q <= 24'h000000;
      end else if (rd_en) begin
         case (addr)
            `PCMC_OFS_PACE: rd_data_q <= pace_q;
            `PCMC_OFS_CMREF: rd_data_q <= cmref_q;
            default: rd_data_q <= 24'h000000;
         endcase
      end else begin
         rd_data_q <= 24'h000000;
      end
   end

   // ==========================================================
   // Pace controls
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pulse_width_filter_on_q <= 1'b1;
         validation_filter_two_on_q <= 1'b1;
         validation_filter_one_on_q <= 1'b1;
         pulse_ch3_lead_choice_q <= PCMC_LEAD_AVF;
         pulse_ch2_lead_choice_q <= PCMC_LEAD_I;
         pulse_ch1_lead_choice_q <= PCMC_LEAD_II;
         pulse_detect_on_q <= 3'h0;
      end else begin
         pulse_width_filter_on_q <= pace_q[`PCMC_PACE_PWF];
         validation_filter_two_on_q <= pace_q[`PCMC_PACE_VF2];
         validation_filter_one_on_q <= pace_q[`PCMC_PACE_VF1];
         pulse_ch3_lead_choice_q <= pcmc_lead_t'(pace_q[`PCMC_PACE_CH3_SEL +: 2]);
         pulse_ch2_lead_choice_q <= pcmc_lead_t'(pace_q[`PCMC_PACE_CH2_SEL +: 2]);
         pulse_ch1_lead_choice_q <= pcmc_lead_t'(pace_q[`PCMC_PACE_CH1_SEL +: 2]);
         pulse_detect_on_q <= pace_q[`PCMC_PACE_CH3_EN:`PCMC_PACE_CH1_EN];
      end
   end

   // ==========================================================
   // Common mode
   logic [2:0] cm_switch;
   pcmc_cm_src_t cm_src;
   logic cm_pin_drive;

   pcmc_cm_route u_route (
      .cm_sel(cmref_q[`PCMC_CM_LA:`PCMC_CM_RA]),
      .external_cm_choice(cmref_q[`PCMC_EXT_CM]),
      .cm_pin_output_on(cmref_q[`PCMC_CM_PIN]),
      .cm_switch(cm_switch),
      .cm_src(cm_src),
      .cm_pin_drive(cm_pin_drive)
   );

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cm_switch_q <= 3'h7;
         cm_src_q <= PCMC_CMS_AVG;
         cm_pin_drive_q <= 1'b0;
      end else begin
         cm_switch_q <= cm_switch;
         cm_src_q <= cm_src;
         cm_pin_drive_q <= cm_pin_drive;
      end
   end

   // ==========================================================
   // Reference drive
   logic [3:0] route_d;

   // A reserved code disconnects the drive rather than guessing a target.
   always_comb begin
      case (pcmc_drvsel_t'(cmref_q[`PCMC_REFSEL_LSB +: 4]))
         PCMC_DRV_PIN: route_d = 4'h1;
         PCMC_DRV_LA: route_d = 4'h2;
         PCMC_DRV_LL: route_d = 4'h4;
         PCMC_DRV_RA: route_d = 4'h8;
         default: route_d = 4'h0;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         drive_sum_q <= 4'h0;
         shared_electrode_ref_on_q <= 1'b0;
         drive_route_q <= 4'h1;
         drive_ref_on_q <= 1'b0;
         shield_drive_on_q <= 1'b0;
      end else begin
         drive_sum_q <= {cmref_q[`PCMC_DRV_LA], cmref_q[`PCMC_DRV_LL],
                         cmref_q[`PCMC_DRV_RA], cmref_q[`PCMC_DRV_CE]};
         shared_electrode_ref_on_q <= cmref_q[`PCMC_CE_REF];
         drive_route_q <= route_d;
         drive_ref_on_q <= cmref_q[`PCMC_DRV_REF];
         shield_drive_on_q <= cmref_q[`PCMC_SHIELD];
      end
   end
endmodule // pcmc_top
`default_nettype wire

// file: tb/pcmc_properties.sv
// Checker for the pace and common-mode config block.
`timescale 1ns/1ps
`default_nettype none
`include "pcmc_map.svh"
module pcmc_checker
   import pcmc_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] addr,
   input wire logic [23:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [23:0] rd_data_q,
   input wire logic [2:0] pulse_detect_on_q,
   input wire logic [2:0] cm_switch_q,
   input wire pcmc_cm_src_t cm_src_q,
   input wire logic cm_pin_drive_q,
   input wire logic shield_drive_on_q
);
   // ==========================================================
   // Properties
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_wr_pace; wr_en && addr == `PCMC_OFS_PACE; endsequence
   sequence s_wr_cm; wr_en && addr == `PCMC_OFS_CMREF; endsequence
   property p_rd_idle; !rd_en |=> rd_data_q == 24'h000000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
   property p_rd_resv; rd_en && addr == `PCMC_OFS_PACE |=> rd_data_q[23:12] == 12'h000; endproperty
   a_rd_resv: assert property (p_rd_resv) else $error("reserved bits read set");
   // Outputs follow the register one edge later, so a write shows two edges on.
   property p_detect; s_wr_pace |-> ##2 pulse_detect_on_q == $past(wr_data[2:0], 2); endproperty
   a_detect: assert property (p_detect) else $error("detect enables wrong");
   property p_shield; s_wr_cm |-> ##2 shield_drive_on_q == $past(wr_data[0], 2); endproperty
   a_shield: assert property (p_shield) else $error("shield enable wrong");
   property p_ext_sel; s_wr_cm ##0 wr_data[2] |-> ##2 cm_src_q == PCMC_CMS_EXT; endproperty
   a_ext_sel: assert property (p_ext_sel) else $error("external mode not taken");
   property p_ext; cm_src_q == PCMC_CMS_EXT |-> cm_switch_q == 3'h0 && !cm_pin_drive_q; endproperty
   a_ext: assert property (p_ext) else $error("switch closed in external mode");
   property p_single; cm_src_q == PCMC_CMS_SINGLE |-> $onehot(cm_switch_q); endproperty
   a_single: assert property (p_single) else $error("single source not one switch");
   property p_intref; cm_src_q == PCMC_CMS_INTREF |-> cm_switch_q == 3'h0; endproperty
   a_intref: assert property (p_intref) else $error("internal source with switch");
   property p_avg; cm_src_q == PCMC_CMS_AVG |-> $countones(cm_switch_q) > 1; endproperty
   a_avg: assert property (p_avg) else $error("average with under two switches");
endmodule // pcmc_checker

bind pcmc_top pcmc_checker u_chk (.clk, .arst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data_q,
   .pulse_detect_on_q, .cm_switch_q, .cm_src_q, .cm_pin_drive_q, .shield_drive_on_q);
`default_nettype wire

// file: tb/pcmc_electrodes.sv
// Electrode network model seen by the common-mode switch outputs.
`timescale 1ns/1ps
`default_nettype none
module pcmc_electrodes
   import pcmc_pkg::*;
(
   input wire logic [2:0] cm_switch,
   input wire pcmc_cm_src_t cm_src,
   output logic [1:0] n_cm,
   output logic ext_in
);
   // ==========================================================
   // Network
   assign n_cm = 2'($countones(cm_switch));
   assign ext_in = cm_src == PCMC_CMS_EXT;
endmodule // pcmc_electrodes
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench of the pace and common-mode config block.
`timescale 1ns/1ps
`default_nettype none
`include "pcmc_map.svh"
module tb_top
   import pcmc_pkg::*;
;
   // ==========================================================
   // Signals
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [23:0] wr_data = 24'h000000;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [23:0] rd_data_q, pace_o, d;
   logic pulse_width_filter_on_q, validation_filter_two_on_q, validation_filter_one_on_q;
   pcmc_lead_t pulse_ch3_lead_choice_q, pulse_ch2_lead_choice_q, pulse_ch1_lead_choice_q;
   logic [2:0] pulse_detect_on_q, cm_switch_q;
   pcmc_cm_src_t cm_src_q;
   logic cm_pin_drive_q, shared_electrode_ref_on_q, drive_ref_on_q, shield_drive_on_q, ext_in;
   logic [3:0] drive_sum_q, drive_route_q;
   logic [1:0] n_cm;
   int miscompares = 0;
   int n_checks = 0;
   always #50 clk = ~clk;
   assign pace_o = {12'h000, pulse_width_filter_on_q, validation_filter_two_on_q,
      validation_filter_one_on_q, pulse_ch3_lead_choice_q, pulse_ch2_lead_choice_q,
      pulse_ch1_lead_choice_q, pulse_detect_on_q};
   pcmc_top dut (.clk, .arst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data_q,
      .pulse_width_filter_on_q, .validation_filter_two_on_q, .validation_filter_one_on_q,
      .pulse_ch3_lead_choice_q, .pulse_ch2_lead_choice_q, .pulse_ch1_lead_choice_q,
      .pulse_detect_on_q, .cm_switch_q, .cm_src_q, .cm_pin_drive_q, .drive_sum_q,
      .shared_electrode_ref_on_q, .drive_route_q, .drive_ref_on_q, .shield_drive_on_q);
   pcmc_electrodes u_net (.cm_switch(cm_switch_q), .cm_src(cm_src_q), .n_cm, .ext_in);
   // ==========================================================
   // Tasks
   task chk(string nm, logic [23:0] seen, logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task give_verdict;
      if (miscompares == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task wr(logic [7:0] a, logic [23:0] v);
      @(posedge clk);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task rd(logic [7:0] a, logic [23:0] exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk("rd_data", rd_data_q, exp);
   endtask
   task cm_out(logic [23:0] v);
      logic [1:0] n;
      n = 2'($countones(v[23:21]));
      chk("cm_switch", 24'(cm_switch_q), v[2] ? 24'h0 : 24'(v[23:21]));
      chk("cm_src", 24'(cm_src_q), v[2] ? 24'h8 : n == 0 ? 24'h4 : n == 1 ? 24'h2 : 24'h1);
      chk("cm_pin", 24'(cm_pin_drive_q), 24'(v[3] & ~v[2]));
      chk("drive", 24'({drive_sum_q, shared_electrode_ref_on_q, drive_ref_on_q, shield_drive_on_q}),
         24'({v[14:12], v[9], v[8], v[1], v[0]}));
      chk("route", 24'(drive_route_q), v[7:4] < 4 ? 24'h1 << v[7:4] : 24'h0);
      chk("ext_in", 24'(ext_in), 24'(v[2]));
      chk("n_cm", 24'(n_cm), v[2] ? 24'h0 : 24'(n));
   endtask
   task t_reset;
      chk("pace_out", pace_o, `PCMC_RST_PACE);
      cm_out(`PCMC_RST_CMREF);
      rd(`PCMC_OFS_PACE, `PCMC_RST_PACE);
      rd(`PCMC_OFS_CMREF, `PCMC_RST_CMREF);
   endtask
   task t_pace;
      logic [23:0] v;
      for (int i = 0; i < 4; i++) begin
         // Each channel walks through every lead code; reserved bits stay zero.
         v = {12'h000, 3'(i), 2'(i), 2'(i + 1), 2'(i + 2), 3'(7 - i)};
         wr(`PCMC_OFS_PACE, v);
         chk("pace_out", pace_o, v);
         rd(`PCMC_OFS_PACE, v);
      end
   endtask
   task t_cm;
      logic [23:0] tbl [12] = '{24'hE00000, 24'h200000, 24'h400000, 24'h800000, 24'h000000,
         24'hE0000C, 24'h600008, 24'h007310, 24'h007320, 24'h007330, 24'h0073F3, 24'h000003};
      foreach (tbl[i]) begin
         wr(`PCMC_OFS_CMREF, tbl[i]);
         cm_out(tbl[i]);
         rd(`PCMC_OFS_CMREF, tbl[i]);
      end
   endtask
   task t_unmapped;
      wr(8'h08, 24'hFFFFFF);
      rd(8'h08, 24'h000000);
      rd(`PCMC_OFS_PACE, 24'h00078C);
      rd(`PCMC_OFS_CMREF, 24'h000003);
      cm_out(24'h000003);
   endtask
   // ==========================================================
   // Sequence
   initial begin
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      t_reset;
      t_pace;
      t_cm;
      t_unmapped;
      give_verdict;
   end
   initial begin
      #500000;
      miscompares++;
      give_verdict;
   end
endmodule // tb_top
`default_nettype wire
